/* File: design/aio_csr.sv */
// Notes on behaviour
// - Target mode uses external sample clock as input rate source.
// - Trigger and output clock caught on falling edge after 60 ns low, in target mode only.
// - Each sync pulse starts the internal synchronization sequence.
// - Optional: sync pulse empties both data buffers.
// - Register window relocatable on any 32-longword boundary.
// - All accesses are 32-bit longwords; host never narrower.
// - External data stream writes input buffer and reads output buffer.
// - Four output channel registers, reset to 8000h.
// - Read-only port pops next input buffer value.
// - Burst rate divider, 24 bits, reset 2760h.
// - Output clock divider, 24 bits, reset 007Eh.
// - Input fill count read-only, zero after reset.
// - Output fill count read-only, zero after reset.
// - Input threshold register, reset 3FFFEh, drives input flag.
// - Output threshold register, reset 3FFFEh, drives output flag.
// - Four scratch registers, reset zero, no internal effect.
// - Write-only port pushes into output buffer.
// - Input configuration holds mask and burst size, reset 0F000400h.
`timescale 1ns/100ps
`default_nettype none
`include "aio_regs.svh"
module aio_csr
   import aio_pkg::*;
#(
   parameter int DEPTH = 16
)
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire aio_req_s    req,
   output logic [31:0]      rdata,
   output logic             rvalid,
   output logic             wready,
   input  wire logic        in_data_valid,
   output logic             in_data_ready,
   input  wire logic [31:0] in_data,
   output logic             out_data_valid,
   input  wire logic        out_data_ready,
   output logic [31:0]      out_data,
   input  wire logic        ext_sample_clk,
   input  wire logic        local_sample_clk,
   output logic             rate_a_source,
   input  wire logic        ext_trigger_n,
   input  wire logic        ext_dac_clk_n,
   output logic             trigger_event,
   output logic             dac_clk_event,
   output logic             sync_start,
   output logic [31:0]      board_control_word,
   output logic [23:0]      burst_div,
   output logic [23:0]      dac_div,
   output logic [31:0]      in_config,
   output logic [127:0]     out_channels
);
   localparam int MIN_LOW = (`AIO_MIN_LOW_NS + `AIO_CLK_NS - 1) / `AIO_CLK_NS;
   localparam int CW      = $clog2(DEPTH) + 1;
   if (MIN_LOW < 1 || MIN_LOW > 14)
   begin
      $error("aio_csr low-width count does not fit its counter");
   end
   logic [31:0] rate_a;
   logic [31:0] in_thr;
   logic [31:0] out_thr;
   logic [31:0] obuf_ctl;
   logic [31:0] trim;
   logic [31:0] cal;
   logic [31:0] dio;
   logic [31:0] aux [4];
   logic [CW-1:0] in_cnt;
   logic [CW-1:0] out_cnt;
   logic [31:0] in_head;
   logic        in_pop;
   logic        out_push;
   logic        out_full_n;
   logic        flush_in;
   logic        flush_out;
   logic [31:0] next_rdata;
   logic [3:0]  trig_cnt;
   logic [3:0]  dclk_cnt;
   logic        trig_prev;
   logic        dclk_prev;
   logic        target;
   function automatic logic [1:0] slot(input logic [6:0] a, input logic [6:0] base);
      logic [6:0] d;
      d = a - base;
      slot = d[3:2];
   endfunction
   assign target    = board_control_word[`AIO_BIT_TARGET];
   assign in_pop    = req.rd && (req.addr == `AIO_OFF_INBUF);
   assign out_push  = req.wr && (req.addr == `AIO_OFF_OUTBUF) && out_full_n;
   assign wready    = !(req.wr && req.addr == `AIO_OFF_OUTBUF) || out_full_n;
   assign flush_in  = board_control_word[`AIO_BIT_CLR_IN]
                      || (sync_start && board_control_word[`AIO_BIT_SYNC_CLR]);
   assign flush_out = board_control_word[`AIO_BIT_CLR_OUT]
                      || (sync_start && board_control_word[`AIO_BIT_SYNC_CLR]);
   assign rate_a_source = target ? ext_sample_clk : local_sample_clk;
   // Input buffer drains to host reads only
   aio_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_in
   (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .flush     (flush_in),
      .in_valid  (in_data_valid),
      .in_ready  (in_data_ready),
      .in_data   (in_data),
      .out_valid (),
      .out_ready (in_pop),
      .out_data  (in_head),
      .count     (in_cnt)
   );
   aio_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_out
   (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .flush     (flush_out),
      .in_valid  (out_push),
      .in_ready  (out_full_n),
      .in_data   (req.wdata),
      .out_valid (out_data_valid),
      .out_ready (out_data_ready),
      .out_data  (out_data),
      .count     (out_cnt)
   );
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         board_control_word <= `AIO_RST_CTRL;
         rate_a             <= `AIO_RST_RATEA;
         obuf_ctl           <= `AIO_RST_OBUFCTL;
         trim               <= `AIO_RST_TRIM;
         cal                <= '0;
         dio                <= '0;
      end
      else
      begin
         board_control_word[`AIO_BIT_CLR_IN]  <= 1'b0;
         board_control_word[`AIO_BIT_CLR_OUT] <= 1'b0;
         if (req.wr)
         begin
            if (req.addr == `AIO_OFF_CTRL)
               board_control_word <= req.wdata;
            else if (req.addr == `AIO_OFF_DIO)
               dio <= req.wdata;
            else if (req.addr == `AIO_OFF_RATEA)
               rate_a <= req.wdata;
            else if (req.addr == `AIO_OFF_CAL)
               cal <= req.wdata;
            else if (req.addr == `AIO_OFF_OBUFCTL)
               obuf_ctl <= req.wdata;
            else if (req.addr == `AIO_OFF_TRIM)
               trim <= req.wdata;
         end
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         out_channels <= {4{`AIO_RST_OUTCH}};
         burst_div    <= `AIO_RST_RATEB;
         dac_div      <= `AIO_RST_RATEC;
         in_config    <= `AIO_RST_INCFG;
         in_thr       <= `AIO_RST_THR;
         out_thr      <= `AIO_RST_THR;
         for (int i = 0; i < 4; i++)
            aux[i] <= '0;
      end
      else if (req.wr)
      begin
         if (req.addr >= `AIO_OFF_OUT0 && req.addr <= `AIO_OFF_OUT3)
            out_channels[slot(req.addr, `AIO_OFF_OUT0)*32 +: 32] <= req.wdata;
         else if (req.addr == `AIO_OFF_RATEB)
            burst_div <= req.wdata[23:0];
         else if (req.addr == `AIO_OFF_INCFG)
            in_config <= req.wdata;
         else if (req.addr == `AIO_OFF_INTHR)
            in_thr <= req.wdata;
         else if (req.addr == `AIO_OFF_OUTTHR)
            out_thr <= req.wdata;
         else if (req.addr == `AIO_OFF_RATEC)
            dac_div <= req.wdata[23:0];
         else if (req.addr >= `AIO_OFF_AUX0 && req.addr <= `AIO_OFF_AUX3)
            aux[slot(req.addr, `AIO_OFF_AUX0)] <= req.wdata;
      end
   end
   always_comb
   begin
      next_rdata = '0;
      if (req.addr == `AIO_OFF_CTRL)
      begin
         next_rdata = board_control_word;
         next_rdata[`AIO_BIT_IN_THR]  = 32'(in_cnt) > in_thr;
         next_rdata[`AIO_BIT_OUT_THR] = 32'(out_cnt) > out_thr;
      end
      else if (req.addr == `AIO_OFF_DIO)
         next_rdata = dio;
      else if (req.addr >= `AIO_OFF_OUT0 && req.addr <= `AIO_OFF_OUT3)
         next_rdata = out_channels[slot(req.addr, `AIO_OFF_OUT0)*32 +: 32];
      else if (req.addr == `AIO_OFF_INBUF)
         next_rdata = (in_cnt != '0) ? in_head : '0;
      else if (req.addr == `AIO_OFF_RATEA)
         next_rdata = rate_a;
      else if (req.addr == `AIO_OFF_RATEB)
         next_rdata = {8'h00, burst_div};
      else if (req.addr == `AIO_OFF_INCFG)
         next_rdata = in_config;
      else if (req.addr == `AIO_OFF_INCNT)
         next_rdata = 32'(in_cnt);
      else if (req.addr == `AIO_OFF_INTHR)
         next_rdata = in_thr;
      else if (req.addr == `AIO_OFF_CAL)
         next_rdata = cal;
      else if (req.addr == `AIO_OFF_OBUFCTL)
         next_rdata = obuf_ctl;
      else if (req.addr == `AIO_OFF_OUTTHR)
         next_rdata = out_thr;
      else if (req.addr == `AIO_OFF_OUTCNT)
         next_rdata = 32'(out_cnt);
      else if (req.addr == `AIO_OFF_RATEC)
         next_rdata = {8'h00, dac_div};
      else if (req.addr >= `AIO_OFF_AUX0 && req.addr <= `AIO_OFF_AUX3)
         next_rdata = aux[slot(req.addr, `AIO_OFF_AUX0)];
      else if (req.addr == `AIO_OFF_TRIM)
         next_rdata = trim;
      else
         next_rdata = '0;
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rdata  <= '0;
         rvalid <= 1'b0;
      end
      else
      begin
         rdata  <= req.rd ? next_rdata : rdata;
         rvalid <= req.rd;
      end
   end
   // Falling edge qualified by low width
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         trig_cnt      <= '0;
         dclk_cnt      <= '0;
         trigger_event <= 1'b0;
         dac_clk_event <= 1'b0;
      end
      else
      begin
         trig_cnt      <= (ext_trigger_n || !target) ? 4'h0 :
                          (trig_cnt == 4'hf ? trig_cnt : trig_cnt + 4'h1);
         dclk_cnt      <= (ext_dac_clk_n || !target) ? 4'h0 :
                          (dclk_cnt == 4'hf ? dclk_cnt : dclk_cnt + 4'h1);
         trigger_event <= target && !ext_trigger_n && (trig_cnt == 4'(MIN_LOW - 1));
         dac_clk_event <= target && !ext_dac_clk_n && (dclk_cnt == 4'(MIN_LOW - 1));
      end
   end
   assign sync_start = trigger_event;
endmodule
`default_nettype wire

/* File: design/aio_regs.svh */
`ifndef AIO_REGS_SVH
`define AIO_REGS_SVH
`define AIO_OFF_CTRL      7'h00
`define AIO_OFF_DIO       7'h04
`define AIO_OFF_OUT0      7'h08
`define AIO_OFF_OUT3      7'h14
`define AIO_OFF_INBUF     7'h18
`define AIO_OFF_RATEA     7'h1c
`define AIO_OFF_RATEB     7'h20
`define AIO_OFF_INCFG     7'h24
`define AIO_OFF_INCNT     7'h28
`define AIO_OFF_INTHR     7'h2c
`define AIO_OFF_STAT      7'h30
`define AIO_OFF_ASSY      7'h34
`define AIO_OFF_CAL       7'h38
`define AIO_OFF_OBUFCTL   7'h3c
`define AIO_OFF_OUTTHR    7'h40
`define AIO_OFF_OUTCNT    7'h44
`define AIO_OFF_OUTBUF    7'h48
`define AIO_OFF_RATEC     7'h4c
`define AIO_OFF_AUX0      7'h50
`define AIO_OFF_AUX3      7'h5c
`define AIO_OFF_TRIM      7'h60
`define AIO_RST_CTRL      32'h22020020
`define AIO_RST_OUTCH     32'h00008000
`define AIO_RST_RATEA     32'h0103f020
`define AIO_RST_RATEB     24'h002760
`define AIO_RST_INCFG     32'h0f000400
`define AIO_RST_THR       32'h0003fffe
`define AIO_RST_OBUFCTL   32'h0000104f
`define AIO_RST_RATEC     24'h00007e
`define AIO_RST_TRIM      32'h00008000
`define AIO_BIT_CLR_IN    13
`define AIO_BIT_IN_THR    14
`define AIO_BIT_TARGET    16
`define AIO_BIT_SYNC_CLR  17
`define AIO_BIT_CLR_OUT   18
`define AIO_BIT_OUT_THR   19
`define AIO_MIN_LOW_NS    60
`define AIO_CLK_NS        10
`endif

/* File: design/aio_pkg.sv */
package aio_pkg;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [6:0]  addr;
      logic [31:0] wdata;
   } aio_req_s;
   typedef enum logic [1:0] {AIO_EDGE_IDLE, AIO_EDGE_LOW, AIO_EDGE_SEEN} aio_edge_e;
endpackage

/* File: design/aio_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module aio_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
)
(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin
      $error("aio_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic             push;
   logic             pop;
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready && !flush;
   assign pop       = out_valid && out_ready && !flush;
   assign out_data  = mem[rptr];
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem[wptr] <= in_data;
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || flush)
      begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wptr <= wptr + AW'(1);
         if (pop)
            rptr <= rptr + AW'(1);
         if (push && !pop)
            count <= count + (AW+1)'(1);
         else if (pop && !push)
            count <= count - (AW+1)'(1);
      end
   end
endmodule
`default_nettype wire

/* File: tb/aio_init_model.sv */
`timescale 1ns/100ps
`default_nettype none
module aio_init_model
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       go,
   input  wire logic [3:0] width,
   output logic            trig_n,
   output logic            dclk_n
);
   logic [3:0] left;
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         left <= 4'h0;
      else if (go)
         left <= width;
      else if (left != 4'h0)
         left <= left - 4'h1;
   end
   assign trig_n = sys_rst | (left == 4'h0);
   assign dclk_n = sys_rst | (left == 4'h0);
endmodule
`default_nettype wire

/* File: tb/aio_csr_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module aio_csr_asserts
   import aio_pkg::*;
(
   input wire logic         clk_sys,
   input wire logic         sys_rst,
   input wire aio_req_s     req,
   input wire logic         rvalid,
   input wire logic         wready,
   input wire logic         ext_sample_clk,
   input wire logic         local_sample_clk,
   input wire logic         rate_a_source,
   input wire logic         ext_trigger_n,
   input wire logic         ext_dac_clk_n,
   input wire logic         trigger_event,
   input wire logic         dac_clk_event,
   input wire logic         sync_start,
   input wire logic [31:0]  board_control_word,
   input wire logic [23:0]  burst_div,
   input wire logic [23:0]  dac_div,
   input wire logic [31:0]  in_config,
   input wire logic [127:0] out_channels
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_rv; rvalid == $past(req.rd); endproperty
   a_rv: assert property (p_rv) else $error("read answer late");
   property p_src; rate_a_source == (board_control_word[16] ? ext_sample_clk : local_sample_clk); endproperty
   a_src: assert property (p_src) else $error("wrong rate source");
   property p_sync; sync_start == trigger_event; endproperty
   a_sync: assert property (p_sync) else $error("sync not from trigger");
   property p_tev; trigger_event |-> !$past(ext_trigger_n) && $past(board_control_word[16]); endproperty
   a_tev: assert property (p_tev) else $error("trigger event without low");
   property p_dev; dac_clk_event |-> !$past(ext_dac_clk_n) && $past(board_control_word[16]); endproperty
   a_dev: assert property (p_dev) else $error("clock event without low");
   property p_one; trigger_event |=> !trigger_event [*3]; endproperty
   a_one: assert property (p_one) else $error("trigger event repeated");
   property p_wr; !wready |-> req.wr && req.addr == 7'h48; endproperty
   a_wr: assert property (p_wr) else $error("spurious refusal");
   property p_rst;
      disable iff (1'b0) sys_rst |=> out_channels == {4{32'h00008000}} && burst_div == 24'h002760
         && dac_div == 24'h00007e && in_config == 32'h0f000400;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   c_trig: cover property (trigger_event);
   c_full: cover property (!wready);
   c_rd: cover property (rvalid);
endmodule
`default_nettype wire

/* File: tb/aio_csr_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module aio_csr_bench
   import aio_pkg::*;
;
   logic         clk_sys, sys_rst, rvalid, wready, in_data_valid, in_data_ready, out_data_valid;
   logic         out_data_ready, ext_sample_clk, local_sample_clk, rate_a_source, ext_trigger_n;
   logic         ext_dac_clk_n, trigger_event, dac_clk_event, sync_start, go;
   aio_req_s     req;
   logic [31:0]  rdata, in_data, out_data, board_control_word, in_config, d, v;
   logic [23:0]  burst_div, dac_div;
   logic [127:0] out_channels;
   logic [3:0]   width;
   logic [31:0]  w [13];
   logic [31:0]  q [$];
   logic [6:0]   wa [13] = '{7'h08, 7'h0c, 7'h10, 7'h14, 7'h20, 7'h24, 7'h4c, 7'h50, 7'h54, 7'h58, 7'h5c,
                             7'h64, 7'h28};
   int           errors, tests_run, cyc, nev;
   aio_csr u_aio_csr (.clk_sys, .sys_rst, .req, .rdata, .rvalid, .wready, .in_data_valid, .in_data_ready,
      .in_data, .out_data_valid, .out_data_ready, .out_data, .ext_sample_clk, .local_sample_clk,
      .rate_a_source, .ext_trigger_n, .ext_dac_clk_n, .trigger_event, .dac_clk_event, .sync_start,
      .board_control_word, .burst_div, .dac_div, .in_config, .out_channels);
   aio_init_model u_aio_init_model (.clk_sys, .sys_rst, .go, .width, .trig_n(ext_trigger_n),
      .dclk_n(ext_dac_clk_n));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      #1;
      ext_sample_clk = 1'($urandom);
      local_sample_clk = 1'($urandom);
      nev = nev + int'(trigger_event === 1'b1) + int'(dac_clk_event === 1'b1);
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] x);
      req = '{1'b0, 1'b1, a, x};
      step(1);
      req = '0;
      step(1);
   endtask
   task automatic rc(input logic [6:0] a, input logic [31:0] e);
      req = '{1'b1, 1'b0, a, 32'h0};
      step(1);
      d = rdata;
      req = '0;
      step(1);
      chk(d, e);
   endtask
   function automatic logic [31:0] rst_of(input logic [6:0] a);
      case (a)
         7'h00: return 32'h22020020;
         7'h08, 7'h0c, 7'h10, 7'h14, 7'h60: return 32'h00008000;
         7'h1c: return 32'h0103f020;
         7'h20: return 32'h00002760;
         7'h24: return 32'h0f000400;
         7'h2c, 7'h40: return 32'h0003fffe;
         7'h3c: return 32'h0000104f;
         7'h4c: return 32'h0000007e;
         default: return 32'h0;
      endcase
   endfunction
   function automatic logic [31:0] wb_of(input logic [6:0] a, input logic [31:0] x);
      case (a)
         7'h20, 7'h4c: return x & 32'h00ffffff;
         7'h28, 7'h64: return 32'h0;
         default: return x;
      endcase
   endfunction
   task automatic pulse(input logic [3:0] n);
      width = n;
      go = 1'b1;
      step(1);
      go = 1'b0;
      step(12);
   endtask
   initial
   begin
      {errors, tests_run, cyc, nev} = '0;
      {req, in_data_valid, in_data, out_data_ready, go} = '0;
      width = 4'h8;
      sys_rst = 1'b1;
      v = $urandom(32'h2b05);
      step(5);
      sys_rst = 1'b0;
      for (int a = 0; a < 128; a += 4)
         if (!(a inside {4, 24, 48, 52, 56, 72}))
            rc(7'(a), rst_of(7'(a)));
      foreach (wa[i])
      begin
         w[i] = $urandom;
         wr(wa[i], w[i]);
         rc(wa[i], wb_of(wa[i], w[i]));
      end
      chk(out_channels[127:96], w[3]);
      chk({8'h0, burst_div}, w[4] & 32'h00ffffff);
      chk({8'h0, dac_div}, w[6] & 32'h00ffffff);
      chk(in_config, w[5]);
      // Fill output buffer with 16 words, then check the next write is refused
      repeat (16)
      begin
         v = $urandom;
         q.push_back(v);
         wr(7'h48, v);
      end
      rc(7'h44, 32'd16);
      req = '{1'b0, 1'b1, 7'h48, 32'h0};
      #1;
      chk({31'h0, wready}, 32'h0);
      step(1);
      req = '0;
      // Drain with a stalling consumer
      while (q.size() > 0)
      begin
         out_data_ready = 1'($urandom);
         chk({31'h0, out_data_valid}, 32'h1);
         if (out_data_ready)
            chk(out_data, q.pop_front());
         step(1);
      end
      out_data_ready = 1'b0;
      rc(7'h44, 32'h0);
      chk({31'h0, out_data_valid}, 32'h0);
      wr(7'h48, 32'h0000a5a5);
      rc(7'h44, 32'h1);
      wr(7'h00, 32'h22062020);
      rc(7'h44, 32'h0);
      rc(7'h00, 32'h22020020);
      wr(7'h00, 32'h22031020);
      chk(board_control_word, 32'h22031020);
      repeat (5)
      begin
         in_data = $urandom;
         q.push_back(in_data);
         in_data_valid = 1'b1;
         step(1);
      end
      in_data_valid = 1'b0;
      chk({31'h0, in_data_ready}, 32'h1);
      rc(7'h28, 32'd5);
      wr(7'h2c, 32'd4);
      rc(7'h00, 32'h22035020);
      wr(7'h2c, 32'd5);
      rc(7'h00, 32'h22031020);
      repeat (4)
         rc(7'h18, q.pop_front());
      pulse(4'h8);
      rc(7'h28, 32'h0);
      chk(32'(nev), 32'd2);
      pulse(4'h3);
      chk(32'(nev), 32'd2);
      rc(7'h18, 32'h0);
      tally_and_finish();
   end
endmodule
bind aio_csr aio_csr_asserts u_aio_csr_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req),
   .rvalid(rvalid), .wready(wready), .ext_sample_clk(ext_sample_clk), .local_sample_clk(local_sample_clk),
   .rate_a_source(rate_a_source), .ext_trigger_n(ext_trigger_n), .ext_dac_clk_n(ext_dac_clk_n),
   .trigger_event(trigger_event), .dac_clk_event(dac_clk_event), .sync_start(sync_start),
   .board_control_word(board_control_word), .burst_div(burst_div), .dac_div(dac_div),
   .in_config(in_config), .out_channels(out_channels));
`default_nettype wire
